// ==== src/fspmg_pkg.sv ====
package fspmg_pkg;

  // ==========================================================
  // register map (byte addresses on the peripheral store bus)
  localparam logic [15:0] FSPMG_UNLOCK_KEY_ADDR   = 16'hffa0;
  localparam logic [15:0] FSPMG_ERROR_STATUS_ADDR = 16'hffa1;
  localparam logic [15:0] FSPMG_MODE_CTRL_ADDR    = 16'hffa2;

  // ==========================================================
  // field positions and values
  localparam int unsigned FSPMG_MODE_BIT_POS   = 0;
  localparam int unsigned FSPMG_PROT_LSB       = 2;
  localparam int unsigned FSPMG_PROT_MSB       = 6;
  localparam int unsigned FSPMG_SEQ_ERR_POS    = 0;
  localparam int unsigned FSPMG_VERIFY_ERR_POS = 1;
  localparam int unsigned FSPMG_WEP_ERR_POS    = 2;
  localparam logic [7:0]  FSPMG_UNLOCK_KEY     = 8'ha5;
  localparam logic [7:0]  FSPMG_STATUS_RESET   = 8'h00;
  localparam logic [7:0]  FSPMG_RDATA_RESET    = 8'h00;
  localparam logic        FSPMG_MODE_RESET     = 1'b0;
  localparam logic [4:0]  FSPMG_PROT_RESET     = 5'h00;

  // ==========================================================
  // timing: halt release after entry into self-programming
  localparam int unsigned FSPMG_CLK_MHZ        = 250;
  localparam int unsigned FSPMG_HALT_REL_US    = 10;
  localparam int unsigned FSPMG_HALT_REL_EXTRA = 2;
  // longest time plus two extra cycles
  localparam int unsigned FSPMG_HALT_REL_CYC   =
    FSPMG_HALT_REL_US * FSPMG_CLK_MHZ + FSPMG_HALT_REL_EXTRA;
  localparam int unsigned FSPMG_TMR_W          = 12;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FSPMG_SEQ_IDLE = 2'b00,
    FSPMG_SEQ_KEY  = 2'b01,
    FSPMG_SEQ_VAL  = 2'b10,
    FSPMG_SEQ_INV  = 2'b11
  } fspmg_seq_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } fspmg_store_type;

  typedef struct packed {
    logic       verify_fail;
    logic       prog_write;
    logic [7:0] prog_data;
    logic [7:0] cell_data;
  } fspmg_prog_ev_type;

endpackage

// ==== src/fspmg_halt_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

module fspmg_halt_timer (
  input  wire logic core_clk,    // core clock
  input  wire logic rst_n,       // async reset, active low
  input  wire logic start,       // pulse: self-prog mode entered
  input  wire logic halt_active, // cpu sits in halt
  output logic      release_pls  // pulse: end the halt
);
  import fspmg_pkg::*;

  localparam logic [FSPMG_TMR_W-1:0] LAST_CNT = FSPMG_TMR_W'(FSPMG_HALT_REL_CYC - 2);

  logic [FSPMG_TMR_W-1:0] cnt_reg;
  logic                   run_reg;

  // ==========================================================
  // count up; release fires one cycle after the last count
  // bounded halt release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (start) begin
      run_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (run_reg) begin
      if (halt_active && cnt_reg >= LAST_CNT) begin
        run_reg <= 1'b0;
      end else if (cnt_reg < LAST_CNT) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      release_pls <= 1'b0;
    end else begin
      release_pls <= run_reg && !start && halt_active && cnt_reg >= LAST_CNT;
    end
  end

endmodule

`default_nettype wire

// ==== src/fspmg_guard.sv ====
`timescale 1ns/100ps
`default_nettype none

module fspmg_guard (
  input  wire logic                       core_clk,        // core clock, 250 MHz
  input  wire logic                       rst_n,           // async reset, active low
  input  wire fspmg_pkg::fspmg_store_type store_req,       // cpu peripheral store
  input  wire logic                       rd_en,           // cpu peripheral read
  input  wire logic [15:0]                rd_addr,         // read address
  input  wire logic [7:0]                 protect_byte,    // stored protect byte
  input  wire fspmg_pkg::fspmg_prog_ev_type prog_ev,       // sequencer events
  input  wire logic                       halt_active,     // cpu halted
  output logic [7:0]                      rd_data,         // read data, next cycle
  output logic                            self_prog_mode_bit, // mode bit
  output logic                            int_inhibit,     // block interrupt service
  output logic                            halt_release,    // pulse: end halt
  output logic [2:0]                      error_flags      // status bits 2..0
);
  import fspmg_pkg::*;

  fspmg_seq_type seq_reg;
  fspmg_seq_type seq_next;
  logic [7:0]    val_reg;
  logic [4:0]    protect_select_field;
  logic          prot_loaded_reg;
  logic          seq_err_set;
  logic          mode_wr_ok;
  logic          enter_pls;
  logic          wep_set;
  logic [7:0]    status_reg;
  logic          sts_wr;

  wire is_key  = store_req.en && store_req.addr == FSPMG_UNLOCK_KEY_ADDR;
  wire is_mode = store_req.en && store_req.addr == FSPMG_MODE_CTRL_ADDR;

  // ==========================================================
  // unlock sequence decode
  always_comb begin
    seq_next    = seq_reg;
    seq_err_set = 1'b0;
    mode_wr_ok  = 1'b0;
    if (is_key) begin
      seq_err_set = seq_reg != FSPMG_SEQ_IDLE;
      seq_next    = (store_req.data == FSPMG_UNLOCK_KEY) ? FSPMG_SEQ_KEY : FSPMG_SEQ_IDLE;
    end else if (is_mode) begin
      unique case (seq_reg)
        FSPMG_SEQ_IDLE: seq_err_set = 1'b1;
        FSPMG_SEQ_KEY: seq_next = FSPMG_SEQ_VAL;
        FSPMG_SEQ_VAL: begin
          if (store_req.data == ~val_reg) begin
            seq_next = FSPMG_SEQ_INV;
          end else begin
            seq_next    = FSPMG_SEQ_IDLE;
            seq_err_set = 1'b1;
          end
        end
        FSPMG_SEQ_INV: begin
          seq_next    = FSPMG_SEQ_IDLE;
          mode_wr_ok  = store_req.data == val_reg;
          seq_err_set = !mode_wr_ok;
        end
      endcase
    end else if (store_req.en && seq_reg != FSPMG_SEQ_IDLE) begin
      seq_next    = FSPMG_SEQ_IDLE;
      seq_err_set = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= FSPMG_SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // key register itself holds nothing readable; only the wanted value is kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      val_reg <= 8'h00;
    end else if (is_mode && seq_reg == FSPMG_SEQ_KEY) begin
      val_reg <= store_req.data;
    end
  end

  // ==========================================================
  // mode bit and protect field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      self_prog_mode_bit <= FSPMG_MODE_RESET;
    end else if (mode_wr_ok) begin
      self_prog_mode_bit <= val_reg[FSPMG_MODE_BIT_POS];
    end
  end

  // strap caught by a clock edge after release, never by the reset itself
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_loaded_reg      <= 1'b0;
      protect_select_field <= FSPMG_PROT_RESET;
    end else if (!prot_loaded_reg) begin
      prot_loaded_reg      <= 1'b1;
      protect_select_field <= protect_byte[FSPMG_PROT_MSB:FSPMG_PROT_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_inhibit <= 1'b0;
    end else begin
      int_inhibit <= mode_wr_ok ? val_reg[FSPMG_MODE_BIT_POS] : self_prog_mode_bit;
    end
  end

  assign enter_pls = mode_wr_ok && val_reg[FSPMG_MODE_BIT_POS] && !self_prog_mode_bit;

  fspmg_halt_timer u_halt_timer (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .start       (enter_pls),
    .halt_active (halt_active),
    .release_pls (halt_release)
  );

  // ==========================================================
  // error status; hardware set wins over software clear
  assign sts_wr  = store_req.en && store_req.addr == FSPMG_ERROR_STATUS_ADDR;
  assign wep_set = prog_ev.prog_write && |(prog_ev.prog_data & ~prog_ev.cell_data);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= FSPMG_STATUS_RESET;
    end else begin
      status_reg[FSPMG_SEQ_ERR_POS] <= seq_err_set ||
        (status_reg[FSPMG_SEQ_ERR_POS] && !(sts_wr && !store_req.data[FSPMG_SEQ_ERR_POS]));
      status_reg[FSPMG_VERIFY_ERR_POS] <= prog_ev.verify_fail ||
        (status_reg[FSPMG_VERIFY_ERR_POS] && !(sts_wr && !store_req.data[FSPMG_VERIFY_ERR_POS]));
      status_reg[FSPMG_WEP_ERR_POS] <= wep_set ||
        (status_reg[FSPMG_WEP_ERR_POS] && !(sts_wr && !store_req.data[FSPMG_WEP_ERR_POS]));
      status_reg[7:3] <= 5'h00;
    end
  end

  assign error_flags = status_reg[2:0];

  // ==========================================================
  // read port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= FSPMG_RDATA_RESET;
    end else if (rd_en) begin
      unique case (rd_addr)
        FSPMG_ERROR_STATUS_ADDR: rd_data <= status_reg;
        FSPMG_MODE_CTRL_ADDR: rd_data <= {1'b0, protect_select_field, 1'b0, self_prog_mode_bit};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks

  // halt bound helper: cycles since entry, saturating; a delay range cannot reach that far
  localparam logic [FSPMG_TMR_W-1:0] HALT_LAST_CNT = FSPMG_TMR_W'(FSPMG_HALT_REL_CYC - 2);

  logic [FSPMG_TMR_W-1:0] entry_cnt_reg;
  logic                   entry_wait_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_wait_reg <= 1'b0;
      entry_cnt_reg  <= '0;
    end else if (enter_pls) begin
      entry_wait_reg <= 1'b1;
      entry_cnt_reg  <= '0;
    end else if (halt_release) begin
      entry_wait_reg <= 1'b0;
    end else if (entry_wait_reg && entry_cnt_reg < HALT_LAST_CNT) begin
      entry_cnt_reg <= entry_cnt_reg + 1'b1;
    end
  end

  a_mode_needs_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(self_prog_mode_bit) |-> $past(seq_reg) == FSPMG_SEQ_INV && $past(is_mode))
    else $error("mode bit changed outside fourth store");

  a_stray_mode_err: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_mode && seq_reg == FSPMG_SEQ_IDLE |=> status_reg[0] && $stable(self_prog_mode_bit))
    else $error("stray mode write not flagged");

  a_foreign_store_err: assert property (@(posedge core_clk) disable iff (!rst_n)
    store_req.en && !is_key && !is_mode && seq_reg != FSPMG_SEQ_IDLE
    |=> status_reg[0] && seq_reg == FSPMG_SEQ_IDLE)
    else $error("foreign store in sequence not flagged");

  a_seq_err_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    sts_wr && !store_req.data[0] && !seq_err_set |=> !status_reg[0])
    else $error("sequence error not cleared by zero");

  a_flag_keep_one: assert property (@(posedge core_clk) disable iff (!rst_n)
    sts_wr && store_req.data[2:0] == 3'h7 |=> status_reg[2:0] == $past(status_reg[2:0])
      || $past(seq_err_set || prog_ev.verify_fail || wep_set))
    else $error("writing one altered a flag");

  a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_reg[7:3] == 5'h00)
    else $error("status upper bits nonzero");

  a_wep_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    wep_set |=> status_reg[2])
    else $error("unerased write not flagged");

  a_verify_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    prog_ev.verify_fail |=> status_reg[1])
    else $error("verify failure not flagged");

  a_int_inhibit: assert property (@(posedge core_clk) disable iff (!rst_n)
    self_prog_mode_bit |-> int_inhibit)
    else $error("interrupts not inhibited in self-prog");

  a_halt_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    entry_wait_reg && halt_active && !halt_release && entry_cnt_reg == HALT_LAST_CNT
    |=> halt_release)
    else $error("halt not released in time");

  a_prot_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
    prot_loaded_reg |=> $stable(protect_select_field))
    else $error("protect field changed");

  c_enter_mode: cover property (@(posedge core_clk) disable iff (!rst_n)
    mode_wr_ok && val_reg[0]);
  c_leave_mode: cover property (@(posedge core_clk) disable iff (!rst_n)
    mode_wr_ok && !val_reg[0] && self_prog_mode_bit);
  c_seq_abort: cover property (@(posedge core_clk) disable iff (!rst_n)
    seq_err_set && seq_reg == FSPMG_SEQ_VAL);
  c_halt_rel: cover property (@(posedge core_clk) disable iff (!rst_n) halt_release);

endmodule

`default_nettype wire

// ==== testbench/fspmg_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// cpu side: peripheral stores, reads and halt
module fspmg_cpu_model #(
  parameter logic [15:0] CMD_ADDR  = 16'hffa8, // command register, placement arbitrary
  parameter logic [15:0] MASK_ADDR = 16'hffe4  // interrupt mask zero, placement arbitrary
) (
  input  wire logic                      core_clk,     // core clock, 250 MHz
  input  wire logic [7:0]                rd_data,      // read data from block
  input  wire logic                      halt_release, // pulse: end halt
  output var fspmg_pkg::fspmg_store_type store_req,    // peripheral store
  output var logic                       rd_en,        // peripheral read
  output var logic [15:0]                rd_addr,      // read address
  output var logic                       halt_active   // cpu halted
);
  import fspmg_pkg::*;

  initial begin
    store_req = '{en: 1'b0, addr: 16'h0000, data: 8'h00};
    rd_en = 1'b0;
    rd_addr = 16'h0000;
    halt_active = 1'b0;
  end

  // idle bus shows a changing pattern, not the old value
  task automatic idle();
    @(negedge core_clk);
    store_req <= '{en: 1'b0, addr: ~store_req.addr, data: ~store_req.data};
  endtask

  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    store_req <= '{en: 1'b1, addr: a, data: d};
    @(posedge core_clk);
  endtask

  task automatic read(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    store_req <= '{en: 1'b0, addr: ~store_req.addr, data: ~store_req.data};
    rd_en <= 1'b1;
    rd_addr <= a;
    @(negedge core_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    d = rd_data;
  endtask

  // key anew, then value, inverse, value
  task automatic switch_mode(input logic [7:0] v);
    store(MASK_ADDR, 8'hff);
    store(CMD_ADDR, 8'h00);
    store(FSPMG_UNLOCK_KEY_ADDR, FSPMG_UNLOCK_KEY);
    store(FSPMG_MODE_CTRL_ADDR, v);
    store(FSPMG_MODE_CTRL_ADDR, ~v);
    store(FSPMG_MODE_CTRL_ADDR, v);
  endtask

  // nop then halt; n counts cycles from entry to release
  task automatic nop_halt(output int n);
    idle();
    @(negedge core_clk);
    halt_active <= 1'b1;
    n = 2;
    while (halt_release !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    halt_active <= 1'b0;
    repeat (2000) @(negedge core_clk);
  endtask
endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
  import fspmg_pkg::*;
  localparam logic [7:0] PROT_BYTE = 8'hbd;
  localparam int         LIMIT     = 20000;

  logic              core_clk;
  logic              rst_n;
  fspmg_store_type   store_req;
  logic              rd_en;
  logic [15:0]       rd_addr;
  logic [7:0]        protect_byte;
  fspmg_prog_ev_type prog_ev;
  logic              halt_active;
  logic [7:0]        rd_data;
  logic              self_prog_mode_bit;
  logic              int_inhibit;
  logic              halt_release;
  logic [2:0]        error_flags;
  int                errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                n;
  int                k;

  fspmg_guard dut (
    .core_clk(core_clk), .rst_n(rst_n), .store_req(store_req), .rd_en(rd_en),
    .rd_addr(rd_addr), .protect_byte(protect_byte), .prog_ev(prog_ev),
    .halt_active(halt_active), .rd_data(rd_data), .self_prog_mode_bit(self_prog_mode_bit),
    .int_inhibit(int_inhibit), .halt_release(halt_release), .error_flags(error_flags)
  );

  fspmg_cpu_model cpu (
    .core_clk(core_clk), .rd_data(rd_data), .halt_release(halt_release),
    .store_req(store_req), .rd_en(rd_en), .rd_addr(rd_addr), .halt_active(halt_active)
  );

  always #2 core_clk = ~core_clk;

  // ==========================================================
  // checking and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.read(a, d);
    check(d, exp);
  endtask

  function automatic logic [7:0] mreg(input logic m);
    return {1'b0, PROT_BYTE[6:2], 1'b0, m};
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    protect_byte = PROT_BYTE;
    prog_ev = '0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    rd_chk(FSPMG_MODE_CTRL_ADDR, mreg(1'b0));
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    rd_chk(FSPMG_UNLOCK_KEY_ADDR, 8'h00);
    rd_chk(16'hffa3, 8'h00);
    cpu.store(FSPMG_UNLOCK_KEY_ADDR, 8'h5a);
    cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h01);
    rd_chk(FSPMG_MODE_CTRL_ADDR, mreg(1'b0));
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h01);
    check({5'h00, error_flags}, 8'h01);
    cpu.store(FSPMG_ERROR_STATUS_ADDR, 8'hff);
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h01);
    cpu.store(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    // value carries protect bits too; they must not move
    cpu.store(FSPMG_UNLOCK_KEY_ADDR, FSPMG_UNLOCK_KEY);
    cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h7d);
    #1 check({7'h00, self_prog_mode_bit}, 8'h00);
    cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h82);
    #1 check({7'h00, self_prog_mode_bit}, 8'h00);
    cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h7d);
    cpu.nop_halt(n);
    check({7'h00, n <= int'(FSPMG_HALT_REL_CYC)}, 8'h01);
    check({6'h00, self_prog_mode_bit, int_inhibit}, 8'h03);
    rd_chk(FSPMG_MODE_CTRL_ADDR, mreg(1'b1));
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    // wrong inverse, then a foreign store, in mid-sequence
    for (k = 0; k < 2; k++) begin
      cpu.store(FSPMG_UNLOCK_KEY_ADDR, FSPMG_UNLOCK_KEY);
      cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h00);
      cpu.store((k == 0) ? FSPMG_MODE_CTRL_ADDR : FSPMG_ERROR_STATUS_ADDR, 8'h00);
      cpu.store(FSPMG_MODE_CTRL_ADDR, 8'h00);
      rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h01);
      rd_chk(FSPMG_MODE_CTRL_ADDR, mreg(1'b1));
      cpu.store(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    end
    // drop the strobe, else the clear store is taken again
    cpu.idle();
    // sequencer events; a 1 over an erased bit is no fault
    @(negedge core_clk);
    prog_ev <= '{verify_fail: 1'b1, prog_write: 1'b0, prog_data: 8'h00, cell_data: 8'h00};
    @(negedge core_clk);
    prog_ev <= '{verify_fail: 1'b0, prog_write: 1'b1, prog_data: 8'h01, cell_data: 8'h01};
    @(negedge core_clk);
    prog_ev <= '0;
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h02);
    @(negedge core_clk);
    prog_ev <= '{verify_fail: 1'b0, prog_write: 1'b1, prog_data: 8'h80, cell_data: 8'h7f};
    @(negedge core_clk);
    prog_ev <= '0;
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h06);
    check({5'h00, error_flags}, 8'h06);
    cpu.store(FSPMG_ERROR_STATUS_ADDR, 8'h05);
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h04);
    // flags cleared before the checked exit
    cpu.store(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    cpu.switch_mode(8'h00);
    rd_chk(FSPMG_MODE_CTRL_ADDR, mreg(1'b0));
    check({7'h00, int_inhibit}, 8'h00);
    rd_chk(FSPMG_ERROR_STATUS_ADDR, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
